/* File: rtl/pidtc_controller.sv */
`timescale 1ns/1ps
`default_nettype none
module pidtc_controller import pidtc_pkg::*; #(
  parameter int SAMPLE_CYCLES_P = SAMPLE_CYCLES,
  parameter int BLINK_CYCLES_P  = BLINK_CYCLES
) (
  input  wire logic               clock,
  input  wire logic               rst_n,
  input  wire logic signed [15:0] temp_x10,
  input  wire logic signed [15:0] setpoint_x10,
  input  wire pidtc_mode_e        mode,
  input  wire logic        [15:0] manual_set_x10,
  input  wire logic               manual_load,
  input  wire logic               bumpless_en,
  input  wire logic        [15:0] pband_x10,
  input  wire logic        [15:0] reset_x100,
  input  wire logic        [15:0] rate_x1000,
  input  wire logic        [15:0] load_x10,
  input  wire logic               autotune_en,
  input  wire logic               high_alarm_en,
  input  wire logic        [15:0] high_alarm_x10,
  input  wire logic               low_alarm_en,
  input  wire logic        [15:0] low_alarm_x10,
  output logic             [15:0] output_percent,
  output logic             [15:0] loop_current_ua,
  output logic                    autotune_active,
  output logic                    high_deviation_alarm,
  output logic                    low_deviation_alarm,
  output logic                    high_alarm_relay,
  output logic                    low_alarm_relay
);

  pidtc_mode_e        mode_q;
  pidtc_tune_e        tune_q;
  pidtc_tune_e        tune_d;
  logic        [31:0] tick_cnt_q;
  logic               tick_q;
  logic        [31:0] blink_cnt_q;
  logic               blink_q;
  logic               at_en_q;
  logic        [15:0] manual_q;
  logic        [15:0] manual_d;
  logic        [15:0] out_d;
  logic        [15:0] tune_cnt_q;
  logic signed [15:0] tmax_q;
  logic signed [15:0] tmin_q;
  logic        [15:0] tuned_pb_q;
  logic        [15:0] tuned_rst_q;
  logic        [15:0] tuned_rate_q;
  logic               tuned_valid_q;
  logic signed [31:0] t_w;
  logic signed [31:0] sp_w;
  logic signed [31:0] man_w;
  logic signed [31:0] pb_w;
  logic signed [31:0] rst_w;
  logic signed [31:0] ticks_w;
  logic               hi_cond_w;
  logic               lo_cond_w;
  logic               enter_man_w;
  logic               tune_start_w;
  logic               tune_abort_w;
  logic               tune_heat_w;
  logic               tune_busy_w;
  logic               at_upper_w;
  logic               at_lower_w;
  logic               measure_w;

  pidtc_law_if lif ();

  pidtc_law u_law (
    .clock (clock),
    .rst_n (rst_n),
    .lif   (lif)
  );

  ////////////////////////////////////////////////////////////////////////
  // settings clamped to their ranges; tuned values replace operator ones
  assign t_w   = 32'(temp_x10);
  assign sp_w  = 32'(setpoint_x10);
  assign man_w = pidtc_sat($signed(32'(manual_set_x10)), 0, OUT_FULL);
  assign pb_w  = tuned_valid_q ? $signed(32'(tuned_pb_q))
                               : pidtc_sat($signed(32'(pband_x10)), PB_MIN, PB_MAX);
  assign rst_w = (reset_x100 == 16'h0000) ? 0
               : pidtc_sat($signed(32'(reset_x100)), RST_MIN, RST_MAX);

  assign lif.tick       = tick_q;
  assign lif.err        = 17'(sp_w - t_w);
  assign lif.band       = 16'(pb_w * SPAN_X10 / PB_SCALE);
  assign lif.reset_rate = tuned_valid_q ? tuned_rst_q : 16'(rst_w);
  assign lif.rate_time  = tuned_valid_q ? tuned_rate_q
                        : 16'(pidtc_sat($signed(32'(rate_x1000)), 0, RATE_MAX));
  assign lif.load       = 16'(pidtc_sat($signed(32'(load_x10)), 0, OUT_FULL));
  assign lif.hold       = (mode != MODE_AUTO) || tune_busy_w;

  ////////////////////////////////////////////////////////////////////////
  // tuning decode: relay drive between setpoint plus and minus one percent
  assign at_upper_w   = t_w >= sp_w + sp_w / TUNE_BAND_DIV;
  assign at_lower_w   = t_w <= sp_w - sp_w / TUNE_BAND_DIV;
  assign tune_start_w = autotune_en && !at_en_q && (mode == MODE_AUTO);
  assign tune_abort_w = !autotune_en || (mode != MODE_AUTO);
  assign tune_heat_w  = (tune_q == TUNE_WARM) || (tune_q == TUNE_RISE);
  assign tune_busy_w  = (tune_q != TUNE_IDLE);
  assign measure_w    = (tune_q == TUNE_RISE) || (tune_q == TUNE_FALL);
  assign ticks_w      = (tune_cnt_q == 16'h0000) ? 1 : $signed(32'(tune_cnt_q));

  // tuning sequence: one settling cycle, then one measured cycle
  always_comb begin
    tune_d = tune_q;
    unique case (tune_q)
      TUNE_IDLE:  if (tune_start_w) tune_d = TUNE_WARM;
      TUNE_WARM:  if (at_upper_w) tune_d = TUNE_COOL;
      TUNE_COOL:  if (at_lower_w) tune_d = TUNE_RISE;
      TUNE_RISE:  if (at_upper_w) tune_d = TUNE_FALL;
      TUNE_FALL:  if (at_lower_w) tune_d = TUNE_APPLY;
      TUNE_APPLY: tune_d = TUNE_IDLE;
      default:    tune_d = TUNE_IDLE;
    endcase
    if (tune_busy_w && tune_abort_w) begin
      tune_d = TUNE_IDLE;
    end
  end

  // cycle period and overshoot capture, parameter derivation
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      tune_q        <= TUNE_IDLE;
      at_en_q       <= 1'b0;
      tune_cnt_q    <= 16'h0000;
      tmax_q        <= 16'sh0000;
      tmin_q        <= 16'sh0000;
      tuned_pb_q    <= 16'h0000;
      tuned_rst_q   <= 16'h0000;
      tuned_rate_q  <= 16'h0000;
      tuned_valid_q <= 1'b0;
    end else begin
      tune_q  <= tune_d;
      at_en_q <= autotune_en;
      if (tune_q == TUNE_COOL) begin
        tune_cnt_q <= 16'h0000;
        tmax_q     <= temp_x10;
        tmin_q     <= temp_x10;
      end else if (measure_w) begin
        if (tick_q && tune_cnt_q != 16'hFFFF) tune_cnt_q <= tune_cnt_q + 16'h0001;
        if (temp_x10 > tmax_q) tmax_q <= temp_x10;
        if (temp_x10 < tmin_q) tmin_q <= temp_x10;
      end
      if (tune_start_w) begin
        tuned_valid_q <= 1'b0;
      end else if (tune_q == TUNE_APPLY && !tune_abort_w) begin
        tuned_pb_q    <= 16'(pidtc_sat(TUNE_P_MUL * ((32'(tmax_q) - 32'(tmin_q)) * PB_SCALE / SPAN_X10),
                                       PB_MIN, PB_MAX));
        tuned_rst_q   <= 16'(pidtc_sat(TUNE_I_NUM / ticks_w, RST_MIN, RST_MAX));
        tuned_rate_q  <= 16'(pidtc_sat(ticks_w * RATE_SCALE / TUNE_D_DEN, 0, RATE_MAX));
        tuned_valid_q <= 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // output selection and manual level handover
  assign enter_man_w = (mode == MODE_MANUAL) && (mode_q != MODE_MANUAL);
  assign manual_d = (enter_man_w && mode_q == MODE_AUTO && bumpless_en) ? output_percent
                  : enter_man_w ? 16'(man_w)
                  : (mode == MODE_MANUAL && manual_load) ? 16'(man_w) : manual_q;
  assign out_d = (mode == MODE_MANUAL) ? manual_q
               : (mode != MODE_AUTO) ? OUT_RST
               : tune_heat_w ? 16'(OUT_FULL)
               : tune_busy_w ? OUT_RST : lif.auto_out;

  // alarm decode around the setpoint
  assign hi_cond_w = high_alarm_en && (t_w > sp_w + $signed(32'(high_alarm_x10)));
  assign lo_cond_w = low_alarm_en && (t_w < sp_w - $signed(32'(low_alarm_x10)));

  // sample tick and flash timebase
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      tick_cnt_q  <= 32'h0000_0000;
      tick_q      <= 1'b0;
      blink_cnt_q <= 32'h0000_0000;
      blink_q     <= 1'b0;
    end else begin
      tick_q      <= (tick_cnt_q == 32'(SAMPLE_CYCLES_P - 1));
      tick_cnt_q  <= (tick_cnt_q == 32'(SAMPLE_CYCLES_P - 1)) ? 32'h0000_0000 : tick_cnt_q + 32'h0000_0001;
      blink_cnt_q <= (blink_cnt_q == 32'(BLINK_CYCLES_P - 1)) ? 32'h0000_0000 : blink_cnt_q + 32'h0000_0001;
      if (blink_cnt_q == 32'(BLINK_CYCLES_P - 1)) blink_q <= !blink_q;
    end
  end

  // registered outputs
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      mode_q               <= MODE_OFF;
      manual_q             <= MANUAL_RST;
      output_percent       <= OUT_RST;
      loop_current_ua      <= 16'(MA_ZERO_UA);
      autotune_active      <= 1'b0;
      high_deviation_alarm <= 1'b0;
      low_deviation_alarm  <= 1'b0;
      high_alarm_relay     <= 1'b0;
      low_alarm_relay      <= 1'b0;
    end else begin
      mode_q               <= mode;
      manual_q             <= manual_d;
      output_percent       <= out_d;
      loop_current_ua      <= 16'(MA_ZERO_UA + 32'(out_d) * MA_STEP_UA);
      autotune_active      <= (tune_d != TUNE_IDLE);
      high_deviation_alarm <= hi_cond_w && blink_q;
      low_deviation_alarm  <= lo_cond_w && blink_q;
      high_alarm_relay     <= hi_cond_w;
      low_alarm_relay      <= lo_cond_w;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!rst_n);

  AST_BUMPLESS: assert property (
    mode == MODE_MANUAL && mode_q == MODE_AUTO && bumpless_en |=> manual_q == $past(output_percent))
    else $error("manual level did not take the last automatic output");

  AST_NO_CARRY: assert property (
    enter_man_w && !bumpless_en |=> manual_q == 16'($past(man_w)))
    else $error("automatic output carried into manual without handover");

  AST_MANUAL_OUT: assert property (
    mode == MODE_MANUAL && mode_q == MODE_MANUAL |=> output_percent == $past(manual_q))
    else $error("manual output not following operator level");

  AST_LOOP_MA: assert property (
    loop_current_ua == 16'(MA_ZERO_UA + 32'(output_percent) * MA_STEP_UA))
    else $error("loop current not linear in output percent");

  AST_TUNE_DRIVE: assert property (
    tune_heat_w && !tune_abort_w && mode == MODE_AUTO |=> output_percent == 16'(OUT_FULL))
    else $error("tuning did not drive full output while heating");

  AST_TUNE_IND: assert property (
    !autotune_en |=> !autotune_active ##1 !autotune_active || $past(autotune_en))
    else $error("tuning indicator on while tuning disabled");

  AST_HIGH_DEVIATION_ALARM: assert property (
    hi_cond_w |=> high_alarm_relay && (high_deviation_alarm == $past(blink_q)))
    else $error("high alarm relay or flash wrong");

  AST_LOW_DEVIATION_ALARM: assert property (
    lo_cond_w |=> low_alarm_relay && (low_deviation_alarm == $past(blink_q)))
    else $error("low alarm relay or flash wrong");

  AST_ALARM_OFF: assert property (
    !high_alarm_en && !low_alarm_en |=> !high_alarm_relay && !low_alarm_relay
                                        && !high_deviation_alarm && !low_deviation_alarm)
    else $error("alarm active while its threshold is off");

endmodule
`default_nettype wire

/* File: rtl/pidtc_law.sv */
`timescale 1ns/1ps
`default_nettype none
module pidtc_law import pidtc_pkg::*; (
  input wire logic clock,
  input wire logic rst_n,
  pidtc_law_if.law lif
);

  logic signed [31:0] acc_q;
  logic signed [31:0] p_prev_q;
  logic        [15:0] out_q;
  logic signed [31:0] err_w;
  logic signed [31:0] band_w;
  logic signed [31:0] rst_w;
  logic signed [31:0] p_w;
  logic signed [31:0] i_w;
  logic signed [31:0] d_w;
  logic signed [63:0] d64_w;
  logic signed [31:0] sum_w;
  logic signed [31:0] acc_next_w;
  logic               in_band_w;
  logic               run_w;

  ////////////////////////////////////////////////////////////////////////
  // proportional term, saturating at the edges of the band
  assign err_w     = 32'(lif.err);
  assign band_w    = $signed({16'h0000, lif.band});
  assign in_band_w = (err_w < band_w) && (err_w > -band_w);
  assign p_w       = pidtc_sat(err_w * OUT_FULL / band_w, -OUT_FULL, OUT_FULL);

  // integral term; anti-windup holds it until the error enters the band
  assign rst_w      = $signed({16'h0000, lif.reset_rate});
  assign acc_next_w = pidtc_sat(acc_q + p_w * rst_w, -ACC_MAX, ACC_MAX);
  assign i_w        = (rst_w == 0) ? 32'sh0000_0000 : acc_q / I_DIV;

  // derivative term: change of proportional term over one sample, times rate time
  // rate time made signed so that a falling error gives a negative kick
  assign d64_w = 64'(p_w - p_prev_q) * $signed(64'(lif.rate_time)) * 64'(TICKS_PER_MIN) / 64'(RATE_SCALE);
  assign d_w   = (d64_w > 64'(OUT_FULL)) ? OUT_FULL : ((d64_w < -64'(OUT_FULL)) ? -OUT_FULL : 32'(d64_w));

  // load demand biases the sum
  assign sum_w        = $signed({16'h0000, lif.load}) + p_w + i_w + d_w;
  assign run_w        = lif.tick && !lif.hold;
  assign lif.auto_out = out_q;

  ////////////////////////////////////////////////////////////////////////
  // sample-rate update of the law
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      acc_q    <= 32'sh0000_0000;
      p_prev_q <= 32'sh0000_0000;
      out_q    <= OUT_RST;
    end else if (lif.hold) begin
      acc_q    <= 32'sh0000_0000;
      p_prev_q <= p_w;
      out_q    <= OUT_RST;
    end else if (lif.tick) begin
      acc_q    <= (rst_w == 0) ? 32'sh0000_0000 : (in_band_w ? acc_next_w : acc_q);
      p_prev_q <= p_w;
      out_q    <= 16'(pidtc_sat(sum_w, 0, OUT_FULL));
    end
  end

  ////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!rst_n);

  AST_BAND_SAT: assert property (
    run_w && rst_w == 0 && lif.rate_time == 16'h0000 && p_prev_q == OUT_FULL && err_w >= band_w
    |=> out_q == 16'(OUT_FULL))
    else $error("output not saturated beyond the band");

  AST_INT_GROWS: assert property (
    run_w && rst_w != 0 && in_band_w && p_w > 0 && acc_q < ACC_MAX |=> acc_q > $past(acc_q))
    else $error("integral did not accumulate a steady error");

  AST_RATE_STEADY: assert property (
    run_w && rst_w == 0 && p_w == p_prev_q
    |=> out_q == 16'(pidtc_sat($signed({16'h0000, $past(lif.load)}) + $past(p_w), 0, OUT_FULL)))
    else $error("derivative acted on a steady error");

  AST_LOAD_BIAS: assert property (
    run_w && rst_w == 0 && lif.rate_time == 16'h0000 && err_w == 0 |=> out_q == $past(lif.load))
    else $error("load demand not presented at zero error");

endmodule
`default_nettype wire

/* File: rtl/pidtc_law_if.sv */
`timescale 1ns/1ps
`default_nettype none
// carries the control error and active settings to the control law
interface pidtc_law_if;
  logic               tick;
  logic signed [16:0] err;
  logic        [15:0] band;
  logic        [15:0] reset_rate;
  logic        [15:0] rate_time;
  logic        [15:0] load;
  logic               hold;
  logic        [15:0] auto_out;
  modport ctl (output tick, err, band, reset_rate, rate_time, load, hold, input auto_out);
  modport law (input tick, err, band, reset_rate, rate_time, load, hold, output auto_out);
endinterface
`default_nettype wire

/* File: rtl/pidtc_pkg.sv */
package pidtc_pkg;

  // operating modes presented by the front panel
  typedef enum logic [1:0] {
    MODE_OFF    = 2'h0,
    MODE_AUTO   = 2'h1,
    MODE_MANUAL = 2'h2
  } pidtc_mode_e;

  // automatic tuning sequence, one-hot
  typedef enum logic [5:0] {
    TUNE_IDLE  = 6'h01,
    TUNE_WARM  = 6'h02,
    TUNE_COOL  = 6'h04,
    TUNE_RISE  = 6'h08,
    TUNE_FALL  = 6'h10,
    TUNE_APPLY = 6'h20
  } pidtc_tune_e;

  // timing
  localparam int CLK_HZ        = 32'h017D_7840;
  localparam int SAMPLE_MS     = 32'h0000_0064;
  localparam int SAMPLE_CYCLES = CLK_HZ / 32'h0000_03E8 * SAMPLE_MS;
  localparam int BLINK_MS      = 32'h0000_00FA;
  localparam int BLINK_CYCLES  = CLK_HZ / 32'h0000_03E8 * BLINK_MS;
  localparam int TICKS_PER_MIN = 32'h0000_EA60 / SAMPLE_MS;

  // scaling: percent in tenths, reset in hundredths, rate in thousandths
  localparam int OUT_FULL   = 32'h0000_03E8;
  localparam int PB_SCALE   = 32'h0000_03E8;
  localparam int SPAN_X10   = 32'h0000_2710;
  localparam int PB_MIN     = 32'h0000_0001;
  localparam int PB_MAX     = 32'h0000_07D0;
  localparam int RST_MIN    = 32'h0000_000A;
  localparam int RST_MAX    = 32'h0000_26AC;
  localparam int RATE_MAX   = 32'h0000_26AC;
  localparam int RST_SCALE  = 32'h0000_0064;
  localparam int RATE_SCALE = 32'h0000_03E8;
  localparam int I_DIV      = RST_SCALE * TICKS_PER_MIN;
  localparam int ACC_MAX    = OUT_FULL * I_DIV;

  // tuning conversion
  localparam int TUNE_BAND_DIV = 32'h0000_0064;
  localparam int TUNE_P_MUL    = 32'h0000_0003;
  localparam int TUNE_I_NUM    = 32'h0000_0002 * RST_SCALE * TICKS_PER_MIN;
  localparam int TUNE_D_DEN    = 32'h0000_0003 * TICKS_PER_MIN;

  // current loop: 4 mA at zero, 16 uA per tenth of a percent
  localparam int MA_ZERO_UA = 32'h0000_0FA0;
  localparam int MA_STEP_UA = 32'h0000_0010;

  // reset values
  localparam logic [15:0] OUT_RST    = 16'h0000;
  localparam logic [15:0] MANUAL_RST = 16'h0000;

  // clamp a signed value into [lo, hi]
  function automatic logic signed [31:0] pidtc_sat(input logic signed [31:0] v,
                                                   input logic signed [31:0] lo,
                                                   input logic signed [31:0] hi);
    pidtc_sat = (v < lo) ? lo : ((v > hi) ? hi : v);
  endfunction

endpackage

/* File: tb/pidtc_plant.sv */
`timescale 1ns/1ps
`default_nettype none
// power controller and heater: loop current of 13.6 mA or more warms, 10.4 mA or less cools
module pidtc_plant (
  input  wire logic               clock,
  input  wire logic               rst_n,
  input  wire logic        [15:0] loop_current_ua,
  input  wire logic               hold_en,
  input  wire logic signed [15:0] hold_temp,
  output logic signed      [15:0] temp_x10
);
  int div_q;

  // thermal step every fourth cycle; hold pins the process at a forced value
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      div_q <= 0;
      temp_x10 <= 16'sh0000;
    end else begin
      div_q <= (div_q + 1) % 4;
      if (hold_en) begin
        temp_x10 <= hold_temp;
      end else if (div_q == 0) begin
        temp_x10 <= temp_x10 + 16'((int'(loop_current_ua) - 12000) / 1600); // 20 mA gives +0.5 degree
      end
    end
  end
endmodule
`default_nettype wire

/* File: tb/test_pid_temperature_controller.sv */
`timescale 1ns/1ps
`default_nettype none
module test_pid_temperature_controller;
  import pidtc_pkg::*;
  localparam int SC = 8;
  localparam int BC = 4;
  logic               clock, rst_n, manual_load, bumpless_en, autotune_en, high_alarm_en, low_alarm_en;
  logic               hold_en, autotune_active, high_deviation_alarm, low_deviation_alarm;
  logic               high_alarm_relay, low_alarm_relay, sh1, sh0, sl1, sl0;
  logic signed [15:0] temp_x10, setpoint_x10, hold_temp;
  logic        [15:0] manual_set_x10, pband_x10, reset_x100, rate_x1000, load_x10;
  logic        [15:0] high_alarm_x10, low_alarm_x10, output_percent, loop_current_ua;
  pidtc_mode_e        mode;
  int                 n_errors, n_tests;
  int                 al[6][5] = '{'{1021,1,1,1,0}, '{1020,1,1,0,0}, '{975,1,1,0,0},
                                   '{974,1,1,0,1}, '{1021,0,1,0,0}, '{974,1,0,0,0}};

  pidtc_controller #(.SAMPLE_CYCLES_P(SC), .BLINK_CYCLES_P(BC)) uut (
    .clock(clock), .rst_n(rst_n), .temp_x10(temp_x10), .setpoint_x10(setpoint_x10), .mode(mode),
    .manual_set_x10(manual_set_x10), .manual_load(manual_load), .bumpless_en(bumpless_en),
    .pband_x10(pband_x10), .reset_x100(reset_x100), .rate_x1000(rate_x1000), .load_x10(load_x10),
    .autotune_en(autotune_en), .high_alarm_en(high_alarm_en), .high_alarm_x10(high_alarm_x10),
    .low_alarm_en(low_alarm_en), .low_alarm_x10(low_alarm_x10), .output_percent(output_percent),
    .loop_current_ua(loop_current_ua), .autotune_active(autotune_active),
    .high_deviation_alarm(high_deviation_alarm), .low_deviation_alarm(low_deviation_alarm),
    .high_alarm_relay(high_alarm_relay), .low_alarm_relay(low_alarm_relay));

  pidtc_plant plant (.clock(clock), .rst_n(rst_n), .loop_current_ua(loop_current_ua),
                     .hold_en(hold_en), .hold_temp(hold_temp), .temp_x10(temp_x10));

  // clock source
  initial begin
    clock = 1'b0;
    forever #20 clock = ~clock;
  end

  ////////////////////////////////////////////////////////////////////////
  // reference model and checks
  function automatic int exp_p(int sp, int t, int pb, int ld);
    int band;
    int p;
    band = (pb < PB_MIN ? PB_MIN : (pb > PB_MAX ? PB_MAX : pb)) * SPAN_X10 / PB_SCALE;
    p = (sp - t) * OUT_FULL / band;
    p = p > OUT_FULL ? OUT_FULL : (p < -OUT_FULL ? -OUT_FULL : p);
    p = p + ld;
    return p > OUT_FULL ? OUT_FULL : (p < 0 ? 0 : p);
  endfunction

  task automatic print_verdict;
    if (n_errors == 0 && n_tests > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
    n_tests++;
    if (got !== exp) begin
      n_errors++;
      $display("[FAIL] %0t %s got %0d expected %0d", $time, what, got, exp);
    end
  endtask

  task automatic chk_bit(input logic got, input logic exp, input string what);
    n_tests++;
    if (got !== exp) begin
      n_errors++;
      $display("[FAIL] %0t %s got %b expected %b", $time, what, got, exp);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge clock);
  endtask

  // bounded waits; running out ends the run
  task automatic wait_out(input logic [15:0] exp, input int lim);
    int k;
    k = 0;
    while (output_percent !== exp && k < lim) begin
      @(posedge clock);
      k++;
    end
    chk(output_percent, exp, "output wait");
    if (output_percent !== exp) print_verdict();
  endtask

  task automatic wait_tune(input logic exp, input int lim);
    int k;
    k = 0;
    while (autotune_active !== exp && k < lim) begin
      @(posedge clock);
      k++;
    end
    chk_bit(autotune_active, exp, "tuning wait");
    if (autotune_active !== exp) print_verdict();
  endtask

  ////////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    int v, a, b, x;
    n_errors = 0;
    n_tests = 0;
    {manual_load, bumpless_en, autotune_en, high_alarm_en, low_alarm_en} = 5'h00;
    {manual_set_x10, reset_x100, rate_x1000, load_x10, high_alarm_x10, low_alarm_x10} = '0;
    pband_x10 = 16'h0064;
    setpoint_x10 = 16'sh03E8;
    hold_temp = 16'sh03E8;
    hold_en = 1'b1;
    mode = MODE_OFF;
    rst_n = 1'b0;
    void'($urandom(65));
    cyc(12);
    rst_n <= 1'b1;
    cyc(2);
    chk(output_percent, OUT_RST, "reset output");
    chk(loop_current_ua, 16'(MA_ZERO_UA), "reset loop");
    chk_bit(autotune_active | high_alarm_relay | low_alarm_relay, 1'b0, "reset flags");
    // manual level: end points, midpoint and random values, error ignored
    mode <= MODE_MANUAL;
    manual_load <= 1'b1;
    for (int i = 0; i < 6; i++) begin
      v = (i < 3) ? i * 500 : $urandom_range(OUT_FULL);
      manual_set_x10 <= 16'(v);
      hold_temp <= 16'($urandom_range(2000));
      cyc(4);
      chk(output_percent, 16'(v), "manual output");
      chk(loop_current_ua, 16'(MA_ZERO_UA + MA_STEP_UA * v), "manual loop");
    end
    // proportional only, band limits and load bias
    mode <= MODE_AUTO;
    manual_load <= 1'b0;
    for (int i = 0; i < 6; i++) begin
      a = (i == 0) ? 0 : (i == 1) ? PB_MIN : (i == 2) ? PB_MAX : $urandom_range(600, 1);
      b = 900 + $urandom_range(200);
      v = $urandom_range(OUT_FULL);
      pband_x10 <= 16'(a);
      hold_temp <= 16'(b);
      load_x10 <= 16'(v);
      cyc(2 * SC + 4);
      x = exp_p(1000, b, a, v);
      chk(output_percent, 16'(x), "auto output");
      chk(loop_current_ua, 16'(MA_ZERO_UA + MA_STEP_UA * x), "auto loop");
    end
    // handover to manual with and without hitchless transfer
    manual_set_x10 <= 16'((x + 300) % 1001);
    bumpless_en <= 1'b1;
    mode <= MODE_MANUAL;
    cyc(4);
    chk(output_percent, 16'(x), "hitchless level");
    mode <= MODE_AUTO;
    cyc(2 * SC + 4);
    bumpless_en <= 1'b0;
    mode <= MODE_MANUAL;
    cyc(4);
    chk_bit(output_percent === 16'(x), 1'b0, "plain handover");
    chk(output_percent, 16'((x + 300) % 1001), "plain level");
    // integral keeps pushing against a steady error
    mode <= MODE_AUTO;
    pband_x10 <= 16'h0064;
    load_x10 <= 16'h0000;
    hold_temp <= 16'sh0384;
    reset_x100 <= 16'(RST_MAX);
    cyc(3 * SC);
    a = output_percent;
    cyc(10 * SC);
    chk_bit(output_percent > 16'(a + 50), 1'b1, "integral growth");
    // derivative kicks on an error step, then fades
    reset_x100 <= 16'h0000;
    rate_x1000 <= 16'(RATE_MAX);
    load_x10 <= 16'h01F4;
    hold_temp <= 16'sh03E8;
    wait_out(16'h0000, SC + 4);
    cyc(3 * SC);
    chk(output_percent, 16'h01F4, "level before step");
    hold_temp <= 16'sh0384;
    wait_out(16'(OUT_FULL), SC + 4);
    wait_out(16'h0258, SC + 4);
    // deviation alarms, thresholds on and off
    rate_x1000 <= 16'h0000;
    high_alarm_x10 <= 16'h0014;
    low_alarm_x10 <= 16'h0019;
    for (int i = 0; i < 6; i++) begin
      hold_temp <= 16'(al[i][0]);
      high_alarm_en <= al[i][1][0];
      low_alarm_en <= al[i][2][0];
      cyc(3);
      chk_bit(high_alarm_relay, al[i][3][0], "high relay");
      chk_bit(low_alarm_relay, al[i][4][0], "low relay");
      {sh1, sh0, sl1, sl0} = 4'h0;
      repeat (2 * BC + 2) begin
        @(posedge clock);
        sh1 |= high_deviation_alarm === 1'b1;
        sh0 |= high_deviation_alarm === 1'b0;
        sl1 |= low_deviation_alarm === 1'b1;
        sl0 |= low_deviation_alarm === 1'b0;
      end
      chk_bit(sh1, al[i][3][0], "high flash on");
      chk_bit(sh0, 1'b1, "high flash off");
      chk_bit(sl1, al[i][4][0], "low flash on");
      chk_bit(sl0, 1'b1, "low flash off");
    end
    // tuning: warm phase at full output, abort, then a full cycle
    chk_bit(autotune_active, 1'b0, "tuner idle");
    hold_temp <= 16'sh0384;
    autotune_en <= 1'b1;
    wait_tune(1'b1, 4);
    wait_out(16'(OUT_FULL), SC + 4);
    autotune_en <= 1'b0;
    cyc(3);
    chk_bit(autotune_active, 1'b0, "tuning aborted");
    hold_en <= 1'b0;
    autotune_en <= 1'b1;
    wait_tune(1'b1, 4);
    wait_tune(1'b0, 20000);
    print_verdict();
  end
endmodule
`default_nettype wire
